// File: esp_pkg.sv
package esp_pkg;
   // ********************************************************************
   // Parameter frame layout
   // ********************************************************************
   localparam int unsigned ESP_PRM_OPBYTE = 10;
   localparam int unsigned ESP_PRM_CPR_HI = 11;
   localparam int unsigned ESP_PRM_CPR_LO = 12;
   localparam int unsigned ESP_PRM_TR_B0 = 13;
   localparam int unsigned ESP_PRM_TR_B3 = 16;
   localparam int unsigned ESP_OP_DIR_BIT = 0;
   localparam int unsigned ESP_OP_CLASS_BIT = 1;
   localparam int unsigned ESP_OP_SCALE_BIT = 3;
   localparam logic [7:0] ESP_OP_RESET = 8'h0a;
   localparam logic [15:0] ESP_CPR_RESET = 16'h1000;
   localparam logic [31:0] ESP_TR_RESET = 32'h0100_0000;
   // ********************************************************************
   // Command word and diagnostics
   // ********************************************************************
   localparam int unsigned ESP_CMD_PRESET_BIT = 31;
   localparam int unsigned ESP_DIAG_LEN = 6;
   localparam logic [7:0] ESP_STAT1_CFG_FAULT = 8'h02;
   localparam logic [7:0] ESP_STAT2_BASE = 8'h04;
   localparam logic [7:0] ESP_STAT3_BASE = 8'h00;
   typedef enum logic [1:0] {ESP_ST_PRM, ESP_ST_EXCH, ESP_ST_ERR} esp_state_t;
endpackage : esp_pkg

// File: esp_range_check.sv
// ***********************************************************************
// Resolution plausibility checker
// ***********************************************************************
module esp_range_check #(
   parameter int unsigned HW_CPR = 8192,
   parameter int unsigned HW_REVS = 4096
) (
   input wire logic [15:0] cpr,
   input wire logic [31:0] total_res,
   output logic cfg_bad,
   output logic revs_pow2
);
   logic [31:0] hw_span;
   logic [31:0] revs;
   // Divider is combinational; parameters are static so the
   // slow path only matters after a parameter frame.
   always_comb begin
      hw_span = 32'(HW_CPR) * 32'(HW_REVS);
      revs = (cpr == 16'h0000) ? 32'h0000_0000 : total_res / 32'(cpr);
      cfg_bad = (cpr == 16'h0000) || (32'(cpr) > 32'(HW_CPR)) ||
                (revs > 32'(HW_REVS)) || (total_res == 32'h0000_0000) ||
                (total_res > hw_span);
      revs_pow2 = (revs != 32'h0000_0000) &&
                  ((revs & (revs - 32'h1)) == 32'h0000_0000);
   end
endmodule // esp_range_check

// File: esp_scaler.sv
// Behaviour
// - Total over counts above hardware revolutions raises error.
// - Any nonzero counts per revolution up to hardware counts is accepted.
// - Revolutions not a power of two: position kept in restricted zone.
// - Total resolution is counts times revolutions, sent as two words.
// - Diagnostic reply is six bytes: status, master id, maker id.
// - Cyclic exchange: four-byte position out, four-byte command in.
// - Command bit 31 rising loads lower bits as current position; zero if past a scaled span.
// - Configuration is taken in every state except cyclic exchange, fault state included.
// - Preset only acts during cyclic data exchange.
// - Class 1 gives position, direction and preset only.
// - Class 2 adds resolution scaling to class 1.
// - Operating bit 0 selects direction; 1 counts up counter-clockwise.
// - Operating bit 1 picks class, default class 2.
// - Operating bit 3 enables scaling with configured resolution.
// - Counts per revolution sits in bytes 11 high and 12 low.
module esp_scaler
   import esp_pkg::*;
#(
   parameter int unsigned HW_CPR = 8192,
   parameter int unsigned HW_REVS = 4096,
   parameter logic [7:0] MAKER_ID_HI = 8'h5a, // Arbitrary value
   parameter logic [7:0] MAKER_ID_LO = 8'ha5 // Arbitrary value
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic prm_valid,
   input wire logic [4:0] prm_index,
   input wire logic [7:0] prm_byte,
   input wire logic prm_done,
   input wire logic exch_mode,
   input wire logic [31:0] cmd_word,
   input wire logic cmd_valid,
   input wire logic shaft_step,
   input wire logic shaft_cw,
   input wire logic [7:0] master_id,
   input wire logic diag_req,
   input wire logic [2:0] diag_index,
   output logic [31:0] position_q,
   output logic [7:0] diag_byte_q,
   output logic diag_valid_q,
   output logic cfg_error_q,
   output logic exchange_q
);
   // ********************************************************************
   // State and configuration
   // ********************************************************************
   esp_state_t state_q, state_d;
   logic [7:0] op_q, op_d;
   logic [15:0] cpr_q, cpr_d;
   logic [31:0] tr_q, tr_d;
   logic [31:0] position_d;
   logic [7:0] diag_byte_d;
   logic diag_valid_d, cfg_error_d, exchange_d;
   logic preset_prev_q, preset_prev_d;
   logic cfg_bad, revs_pow2, scale_on, preset_rise, up;
   logic [31:0] span;

   esp_range_check #(.HW_CPR(HW_CPR), .HW_REVS(HW_REVS)) u_check (
      .cpr(cpr_q),
      .total_res(tr_q),
      .cfg_bad(cfg_bad),
      .revs_pow2(revs_pow2)
   );

   // Scaling needs class 2 and the scaling bit both set
   assign scale_on = op_q[ESP_OP_CLASS_BIT] &&
                     op_q[ESP_OP_SCALE_BIT];
   // Hardware span when scaling is off, class 1 never scales
   assign span = scale_on ? tr_q : 32'(HW_CPR) * 32'(HW_REVS);
   // Only the edge counts, so a held bit does not freeze the position
   assign preset_rise = cmd_valid && cmd_word[ESP_CMD_PRESET_BIT] &&
                        !preset_prev_q;
   // Direction flip: counter-clockwise counts up when bit set
   assign up = shaft_cw ^ op_q[ESP_OP_DIR_BIT];

   // ********************************************************************
   // Next state
   // ********************************************************************
   always_comb begin
      state_d = state_q;
      op_d = op_q;
      cpr_d = cpr_q;
      tr_d = tr_q;
      position_d = position_q;
      preset_prev_d = preset_prev_q;
      // Parameter bytes latched in any state but exchange, fault state included
      if (state_q != ESP_ST_EXCH && prm_valid) begin
         if (32'(prm_index) == ESP_PRM_OPBYTE) begin
            op_d = prm_byte;
         end else if (32'(prm_index) == ESP_PRM_CPR_HI) begin
            cpr_d[15:8] = prm_byte;
         end else if (32'(prm_index) == ESP_PRM_CPR_LO) begin
            cpr_d[7:0] = prm_byte;
         end else if (32'(prm_index) >= ESP_PRM_TR_B0 &&
                      32'(prm_index) <= ESP_PRM_TR_B3) begin
            // High word first, big-endian bytes
            case (prm_index - 5'(ESP_PRM_TR_B0))
               5'h00: tr_d[31:24] = prm_byte;
               5'h01: tr_d[23:16] = prm_byte;
               5'h02: tr_d[15:8] = prm_byte;
               default: tr_d[7:0] = prm_byte;
            endcase
         end
      end
      case (state_q)
         ESP_ST_PRM: begin
            if (prm_done) begin
               // Bad values only matter when scaling uses them
               if (scale_on && cfg_bad) begin
                  state_d = ESP_ST_ERR;
               end else if (exch_mode) begin
                  state_d = ESP_ST_EXCH;
                  // Old position may lie past a smaller new span
                  if (position_q >= span) begin
                     position_d = 32'h0000_0000;
                  end
               end
            end
         end
         ESP_ST_EXCH: begin
            if (!exch_mode) begin
               state_d = ESP_ST_PRM;
            end else if (preset_rise) begin
               position_d = cmd_word[30:0] < span[30:0] || !scale_on ?
                            {1'b0, cmd_word[30:0]} : 32'h0000_0000;
            end else if (shaft_step) begin
               // Wrap inside span, configured or hardware when unscaled; covers red zone
               if (up) begin
                  position_d = (position_q + 32'h1 >= span) ?
                               32'h0000_0000 : position_q + 32'h1;
               end else begin
                  position_d = (position_q == 32'h0000_0000) ?
                               span - 32'h1 : position_q - 32'h1;
               end
            end
         end
         ESP_ST_ERR: begin
            // New parameter frame clears the fault
            if (prm_valid) begin
               state_d = ESP_ST_PRM;
            end
         end
         default: state_d = ESP_ST_PRM;
      endcase
      // Bit-31 history; master drops it to end preset
      if (cmd_valid) begin
         preset_prev_d = cmd_word[ESP_CMD_PRESET_BIT];
      end
   end

   // ********************************************************************
   // Status and diagnostics
   // ********************************************************************
   always_comb begin
      cfg_error_d = (state_d == ESP_ST_ERR);
      exchange_d = (state_d == ESP_ST_EXCH);
      diag_valid_d = diag_req && (32'(diag_index) < ESP_DIAG_LEN);
      case (diag_index)
         3'h0: diag_byte_d = cfg_error_q ? ESP_STAT1_CFG_FAULT : 8'h00;
         3'h1: diag_byte_d = ESP_STAT2_BASE;
         3'h2: diag_byte_d = ESP_STAT3_BASE;
         3'h3: diag_byte_d = master_id;
         3'h4: diag_byte_d = MAKER_ID_HI;
         3'h5: diag_byte_d = MAKER_ID_LO;
         default: diag_byte_d = 8'h00;
      endcase
      if (!diag_req) begin
         diag_byte_d = 8'h00;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= ESP_ST_PRM;
         op_q <= ESP_OP_RESET;
         cpr_q <= ESP_CPR_RESET;
         tr_q <= ESP_TR_RESET;
         position_q <= 32'h0000_0000;
         preset_prev_q <= 1'b0;
         diag_byte_q <= 8'h00;
         diag_valid_q <= 1'b0;
         cfg_error_q <= 1'b0;
         exchange_q <= 1'b0;
      end else begin
         state_q <= state_d;
         op_q <= op_d;
         cpr_q <= cpr_d;
         tr_q <= tr_d;
         position_q <= position_d;
         preset_prev_q <= preset_prev_d;
         diag_byte_q <= diag_byte_d;
         diag_valid_q <= diag_valid_d;
         cfg_error_q <= cfg_error_d;
         exchange_q <= exchange_d;
      end
   end

   // ********************************************************************
   // Checks
   // ********************************************************************
   property p_preset_load;
      @(posedge core_clk) disable iff (!rstn)
      (state_q == ESP_ST_EXCH && exch_mode && preset_rise && !scale_on)
      |=> position_q == {1'b0, $past(cmd_word[30:0])};
   endproperty
   a_preset_load: assert property (p_preset_load)
      else $error("preset not loaded");

   property p_preset_once;
      @(posedge core_clk) disable iff (!rstn)
      (state_q == ESP_ST_EXCH && exch_mode && cmd_valid && !shaft_step &&
       cmd_word[ESP_CMD_PRESET_BIT] && preset_prev_q) |=> $stable(position_q);
   endproperty
   a_preset_once: assert property (p_preset_once)
      else $error("preset reloaded while held");

   property p_no_preset_prm;
      @(posedge core_clk) disable iff (!rstn)
      (state_q != ESP_ST_EXCH && !prm_done) |=> $stable(position_q);
   endproperty
   a_no_preset_prm: assert property (p_no_preset_prm)
      else $error("position moved outside exchange");

   property p_cfg_frozen;
      @(posedge core_clk) disable iff (!rstn)
      (state_q == ESP_ST_EXCH) |=> $stable(op_q) && $stable(cpr_q);
   endproperty
   a_cfg_frozen: assert property (p_cfg_frozen)
      else $error("config changed in exchange");

   property p_err_entry;
      @(posedge core_clk) disable iff (!rstn)
      (state_q == ESP_ST_PRM && prm_done && scale_on && cfg_bad)
      |=> cfg_error_q;
   endproperty
   a_err_entry: assert property (p_err_entry)
      else $error("config fault not flagged");

   property p_in_span;
      @(posedge core_clk) disable iff (!rstn)
      (state_q == ESP_ST_EXCH && scale_on && !cfg_bad) |-> position_q < span;
   endproperty
   a_in_span: assert property (p_in_span)
      else $error("position outside span");

   property p_red_zone;
      @(posedge core_clk) disable iff (!rstn)
      (state_q == ESP_ST_EXCH && exch_mode && scale_on && !revs_pow2 &&
       shaft_step && !preset_rise && up && position_q == tr_q - 32'h1)
      |=> position_q == 32'h0000_0000;
   endproperty
   a_red_zone: assert property (p_red_zone)
      else $error("red zone wrap missed");

   property p_diag_master;
      @(posedge core_clk) disable iff (!rstn)
      (diag_req && diag_index == 3'h3) |=> diag_valid_q &&
      diag_byte_q == $past(master_id);
   endproperty
   a_diag_master: assert property (p_diag_master)
      else $error("diag master id wrong");

   property p_class1_noscale;
      @(posedge core_clk) disable iff (!rstn)
      (!op_q[ESP_OP_CLASS_BIT] && state_q == ESP_ST_PRM && prm_done &&
       exch_mode) |=> exchange_q && !cfg_error_q;
   endproperty
   a_class1_noscale: assert property (p_class1_noscale)
      else $error("class 1 scaled");
endmodule // esp_scaler

// File: esp_master_model.sv
// ****************************************
// Fieldbus master stand-in
// ****************************************
module esp_master_model
   import esp_pkg::*;
(
   input wire logic core_clk,
   output logic prm_valid,
   output logic [4:0] prm_index,
   output logic [7:0] prm_byte,
   output logic prm_done,
   output logic exch_mode,
   output logic [31:0] cmd_word,
   output logic cmd_valid
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle master at time zero
   initial begin
      {prm_valid, prm_index, prm_byte, prm_done} = '0;
      {exch_mode, cmd_word, cmd_valid} = '0;
   end
   // Phase level only; a refused preset needs it low
   task automatic set_phase(input logic x);
      @(negedge core_clk);
      exch_mode = x;
   endtask
   // Whole frame, then rejoin exchange and wait out the answer
   task automatic send_prm(input logic [7:0] op, input logic [15:0] cpr,
         input logic [31:0] tot);
      logic [7:0] f [7];
      f = '{op, cpr[15:8], cpr[7:0], tot[31:24], tot[23:16], tot[15:8],
         tot[7:0]};
      set_phase(1'b0);
      for (int i = 0; i < 7; i++) begin
         @(negedge core_clk);
         prm_valid = 1'b1;
         prm_index = 5'(ESP_PRM_OPBYTE + i);
         prm_byte = f[i];
      end
      @(negedge core_clk);
      prm_valid = 1'b0;
      prm_byte = ~prm_byte; // Released data is not held
      prm_done = 1'b1;
      exch_mode = 1'b1;
      @(negedge core_clk);
      prm_done = 1'b0;
      repeat (2) @(negedge core_clk);
   endtask
   // Stray byte while exchanging; the slave must drop it
   task automatic stray_prm(input logic [4:0] idx, input logic [7:0] b);
      @(negedge core_clk);
      {prm_valid, prm_index, prm_byte} = {1'b1, idx, b};
      @(negedge core_clk);
      prm_valid = 1'b0;
   endtask
   // One command word; bit 31 low ends a preset
   task automatic send_cmd(input logic [31:0] w);
      @(negedge core_clk);
      cmd_word = w;
      cmd_valid = 1'b1;
      @(negedge core_clk);
      cmd_valid = 1'b0;
      cmd_word = ~w;
   endtask
endmodule // esp_master_model

// File: encoder_scaling_preset_bench.sv
// ****************************************
// Bench with integer model
// ****************************************
module encoder_scaling_preset_bench
   import esp_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned HW_CPR = 8192;
   localparam int unsigned HW_REVS = 4096;
   localparam logic [7:0] ID_HI = 8'h3c; // Arbitrary value
   localparam logic [7:0] ID_LO = 8'hc3; // Arbitrary value
   logic core_clk, rstn, shaft_step, shaft_cw, diag_req;
   logic [7:0] master_id;
   logic [2:0] diag_index;
   logic prm_valid, prm_done, exch_mode, cmd_valid;
   logic [4:0] prm_index;
   logic [7:0] prm_byte, diag_byte_q;
   logic [31:0] cmd_word, position_q;
   logic diag_valid_q, cfg_error_q, exchange_q;
   int failures = 0;
   int samples_checked = 0;
   longint unsigned pos_m, span_m;
   logic dir_m, exch_m, sc_m;
   logic b31_m = 1'b0;
   int unsigned tc [4] = '{360, 8193, 8192, 100};
   longint unsigned tt [4] = '{33554432, 8193, 33554432, 100};
   esp_scaler #(.HW_CPR(HW_CPR), .HW_REVS(HW_REVS), .MAKER_ID_HI(ID_HI),
      .MAKER_ID_LO(ID_LO)) DUT (.core_clk(core_clk), .rstn(rstn),
      .prm_valid(prm_valid), .prm_index(prm_index), .prm_byte(prm_byte),
      .prm_done(prm_done), .exch_mode(exch_mode), .cmd_word(cmd_word),
      .cmd_valid(cmd_valid), .shaft_step(shaft_step), .shaft_cw(shaft_cw),
      .master_id(master_id), .diag_req(diag_req), .diag_index(diag_index),
      .position_q(position_q), .diag_byte_q(diag_byte_q),
      .diag_valid_q(diag_valid_q), .cfg_error_q(cfg_error_q),
      .exchange_q(exchange_q));
   esp_master_model MST (.core_clk(core_clk), .prm_valid(prm_valid),
      .prm_index(prm_index), .prm_byte(prm_byte), .prm_done(prm_done),
      .exch_mode(exch_mode), .cmd_word(cmd_word), .cmd_valid(cmd_valid));
   // 100 ns clock
   always #50 core_clk = ~core_clk;
   // ****************************************
   // Checking and closing
   // ****************************************
   task automatic check(input string what, input logic [31:0] exp,
         input logic [31:0] seen);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Hang guard
   initial begin
      repeat (20000) @(posedge core_clk);
      failures++;
      complete_run();
   end
   // ****************************************
   // Stimulus tasks with model update
   // ****************************************
   task automatic cfg(input logic [7:0] op, input int unsigned cpr,
         input longint unsigned tot);
      logic sc, err;
      sc = op[1] & op[3];
      err = sc && (cpr == 0 || cpr > HW_CPR || tot == 0 ||
         tot > HW_CPR * HW_REVS || tot / cpr > HW_REVS);
      span_m = sc ? tot : HW_CPR * HW_REVS;
      {dir_m, exch_m, sc_m} = {op[0], !err, sc};
      MST.send_prm(op, cpr[15:0], tot[31:0]);
      // A smaller span pulls a stale position back to zero
      if (exch_m && pos_m >= span_m) pos_m = 0;
      check("position", pos_m[31:0], position_q);
      check("cfg_error", 32'(err), 32'(cfg_error_q));
      check("exchange", 32'(exch_m), 32'(exchange_q));
   endtask
   task automatic pre(input logic [31:0] w);
      MST.send_cmd(w);
      if (exch_m && w[31] && !b31_m)
         pos_m = (sc_m && w[30:0] >= span_m) ? 0 : w[30:0];
      b31_m = w[31];
      check("position", pos_m[31:0], position_q);
   endtask
   // Shaft count; 8192 counts a turn keeps one step one count
   task automatic step(input logic cw);
      @(negedge core_clk);
      {shaft_step, shaft_cw} = {1'b1, cw};
      @(negedge core_clk);
      shaft_step = 1'b0;
      if (cw ^ dir_m) pos_m = (pos_m + 1 == span_m) ? 0 : pos_m + 1;
      else pos_m = (pos_m == 0) ? span_m - 1 : pos_m - 1;
      check("position", pos_m[31:0], position_q);
   endtask
   task automatic diag(input logic [2:0] idx, input logic [7:0] exp);
      @(negedge core_clk);
      {diag_req, diag_index} = {1'b1, idx};
      @(negedge core_clk);
      check("diag_valid", 32'h1, 32'(diag_valid_q));
      check("diag_byte", 32'(exp), 32'(diag_byte_q));
      {diag_req, diag_index} = {1'b0, ~idx};
      @(negedge core_clk);
      check("diag_idle", 32'h0, 32'(diag_byte_q));
      check("diag_valid", 32'h0, 32'(diag_valid_q));
   endtask
   // Main sequence
   initial begin
      {core_clk, rstn, shaft_step, shaft_cw, diag_req} = '0;
      {master_id, diag_index} = '0;
      void'($urandom(36897));
      repeat (20) @(negedge core_clk);
      check("reset_pos", 32'h0, position_q);
      rstn = 1'b1;
      cfg(8'h0a, 8192, 33554432);
      pre(32'h80000500);
      pre(32'h80000777);
      pre(32'h00000777);
      pre(32'h80000000 | $urandom_range(100, 30000000));
      pre(32'h00000000);
      for (int i = 0; i < 12; i++) step(1'($urandom_range(0, 1)));
      // Direction byte sent in exchange must be ignored
      MST.stray_prm(5'(ESP_PRM_OPBYTE), 8'h01);
      step(1'b1);
      master_id = 8'($urandom);
      diag(3'h3, master_id);
      diag(3'h4, ID_HI);
      diag(3'h5, ID_LO);
      diag(3'h0, 8'h00);
      diag(3'h1, ESP_STAT2_BASE);
      diag(3'h2, ESP_STAT3_BASE);
      cfg(8'h0b, 8192, 33554432);
      pre(32'h80000010);
      step(1'b1);
      step(1'b0);
      pre(32'h00000000);
      cfg(8'h0a, 8192, 409600);
      pre(32'h80070000);
      pre(32'h00000000);
      pre(32'h80063fff);
      step(1'b1);
      step(1'b0);
      pre(32'h00000000);
      for (int i = 0; i < 4; i++) begin
         cfg(8'h0a, tc[i], tt[i]);
         diag(3'h0, exch_m ? 8'h00 : ESP_STAT1_CFG_FAULT);
      end
      cfg(8'h08, 360, 33554432);
      pre(32'h80000003);
      step(1'b0);
      cfg(8'h02, 360, 33554432);
      pre(32'h00000000);
      MST.set_phase(1'b0);
      exch_m = 1'b0;
      pre(32'h80001234);
      check("exchange", 32'h0, 32'(exchange_q));
      complete_run();
   end
endmodule // encoder_scaling_preset_bench
